// *** secsi_params.svh ***
`ifndef SECSI_PARAMS_SVH
`define SECSI_PARAMS_SVH
`define ADDR_UNLOCK1_W   12'h555
`define ADDR_UNLOCK2_W   12'h2AA
`define ADDR_UNLOCK1_B   12'hAAA
`define ADDR_UNLOCK2_B   12'h554
`define DATA_UNLOCK1     16'h00AA
`define DATA_UNLOCK2     16'h0055
`define DATA_ENTRY       16'h0088
`define DATA_PROG_SETUP  16'h00A0
`define DATA_EXIT        16'h0090
`define ADDR_EXIT_TAIL   12'h000
`define DATA_EXIT_TAIL   16'h0000
`define REGION_WORDS     256
`define FACTORY_LAST     8'h7F
`endif

// *** secsi_pkg.sv ***
package secsi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_UNL1,
    ST_UNL2,
    ST_PROG
  } cmd_state_t;
  typedef enum logic [2:0] {
    H_IDLE,
    H_WR,
    H_DONE
  } host_state_t;
  typedef enum logic [1:0] {
    OP_ENTER,
    OP_PROGRAM,
    OP_EXIT
  } host_op_t;
endpackage

// *** secsi_if.sv ***
`timescale 1ns/1ns
interface secsi_if #(
  parameter int AW = 24,
  parameter int DW = 16
);
  logic          wr;
  logic          byte_mode;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  modport dev (input wr, byte_mode, addr, wdata);
  modport host (output wr, byte_mode, addr, wdata);
endinterface

// *** secsi_dev.sv ***
`timescale 1ns/1ns
`include "secsi_params.svh"
module secsi_dev #(
  parameter int AW     = 24,
  parameter int DW     = 16,
  parameter int SEC_AW = 15
) (
  input  wire logic            i_ref_clk,
  input  wire logic            i_arst_n,
  secsi_if.dev                 bus,
  input  wire logic            i_busy,
  output logic                 o_region_mapped,
  output logic                 o_prog_stb,
  output logic                 o_prog_region,
  output logic                 o_prog_factory,
  output logic [AW-1:0]        o_prog_addr,
  output logic [DW-1:0]        o_prog_data,
  input  wire logic [AW-1:0]   i_rd_addr,
  output logic                 o_rd_region,
  output logic [7:0]           o_rd_region_addr
);
  import secsi_pkg::*;

  typedef struct packed {
    secsi_pkg::cmd_state_t st;
    logic                  mapped;
    logic                  stb;
    logic                  preg;
    logic                  pfac;
    logic [AW-1:0]         paddr;
    logic [DW-1:0]         pdata;
    logic                  rreg;
    logic [7:0]            raddr;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;

  // ------------------------------------------------------------
  // command address match, word or byte form
  // ------------------------------------------------------------
  function automatic logic is_off(input logic [AW-1:0] a, input logic bm,
                                  input logic [11:0] w, input logic [11:0] b);
    is_off = bm ? (a == AW'(b)) : (a == AW'(w));
  endfunction

  function automatic logic in_sector0(input logic [AW-1:0] a);
    in_sector0 = (a >> SEC_AW) == '0;
  endfunction

  logic u1;
  logic u2;
  logic cmd_a;
  always_comb begin
    u1    = is_off(bus.addr, bus.byte_mode, `ADDR_UNLOCK1_W, `ADDR_UNLOCK1_B);
    u2    = is_off(bus.addr, bus.byte_mode, `ADDR_UNLOCK2_W, `ADDR_UNLOCK2_B);
    cmd_a = u1;
  end

  // ------------------------------------------------------------
  // sequence decoder
  // ------------------------------------------------------------
  always_comb begin
    s_nxt     = s_r;
    s_nxt.stb = 1'b0;
    // mapped region decode covers all of sector 0 (address bits above SEC_AW zero); only the low 8 bits are forwarded
    s_nxt.rreg  = s_r.mapped && in_sector0(i_rd_addr);
    s_nxt.raddr = i_rd_addr[7:0];
    if (bus.wr) begin
      if (i_busy) begin
        s_nxt.st = ST_IDLE;
      end else begin
        case (s_r.st)
          ST_IDLE: begin
            if (u1 && bus.wdata == `DATA_UNLOCK1) s_nxt.st = ST_UNL1;
          end
          ST_UNL1: begin
            if (u2 && bus.wdata == `DATA_UNLOCK2) s_nxt.st = ST_UNL2;
            else s_nxt.st = ST_IDLE;
          end
          ST_UNL2: begin
            s_nxt.st = ST_IDLE;
            if (cmd_a && bus.wdata == `DATA_ENTRY) begin
              s_nxt.mapped = 1'b1;
            end else if (cmd_a && bus.wdata == `DATA_EXIT) begin
              s_nxt.mapped = 1'b0;
            end else if (cmd_a && bus.wdata == `DATA_PROG_SETUP) begin
              s_nxt.st = ST_PROG;
            end
          end
          ST_PROG: begin
            s_nxt.st    = ST_IDLE;
            s_nxt.stb   = 1'b1;
            s_nxt.paddr = bus.addr;
            s_nxt.pdata = bus.wdata;
            s_nxt.preg  = s_r.mapped && in_sector0(bus.addr);
            s_nxt.pfac  = bus.addr[7:0] <= `FACTORY_LAST;
          end
          default: s_nxt.st = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_region_mapped  = s_r.mapped;
  assign o_prog_stb       = s_r.stb;
  assign o_prog_region    = s_r.preg;
  assign o_prog_factory   = s_r.pfac;
  assign o_prog_addr      = s_r.paddr;
  assign o_prog_data      = s_r.pdata;
  assign o_rd_region      = s_r.rreg;
  assign o_rd_region_addr = s_r.raddr;
endmodule

// *** secsi_host.sv ***
`timescale 1ns/1ns
`include "secsi_params.svh"
module secsi_host #(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_arst_n,
  secsi_if.host                    bus,
  input  wire logic                i_start,
  input  wire secsi_pkg::host_op_t i_op,
  input  wire logic                i_byte_mode,
  input  wire logic [AW-1:0]       i_addr,
  input  wire logic [DW-1:0]       i_data,
  output logic                     o_busy,
  output logic                     o_done
);
  import secsi_pkg::*;

  typedef struct packed {
    secsi_pkg::host_state_t st;
    secsi_pkg::host_op_t    op;
    logic [2:0]             step;
    logic                   bm;
    logic [AW-1:0]          ua;
    logic [DW-1:0]          ud;
    logic                   wr;
    logic [AW-1:0]          addr;
    logic [DW-1:0]          wdata;
    logic                   done;
  } host_reg_t;

  host_reg_t s_r;
  host_reg_t s_nxt;

  function automatic logic [AW-1:0] off(input logic bm, input logic [11:0] w,
                                        input logic [11:0] b);
    off = bm ? AW'(b) : AW'(w);
  endfunction

  // ------------------------------------------------------------
  // write sequencer: one write per cycle
  // ------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.wr   = 1'b0;
    s_nxt.done = 1'b0;
    case (s_r.st)
      H_IDLE: begin
        if (i_start) begin
          s_nxt.st   = H_WR;
          s_nxt.op   = i_op;
          s_nxt.bm   = i_byte_mode;
          s_nxt.ua   = i_addr;
          s_nxt.ud   = i_data;
          s_nxt.step = 3'h0;
        end
      end
      H_WR: begin
        s_nxt.wr   = 1'b1;
        s_nxt.step = s_r.step + 3'h1;
        case (s_r.step)
          3'h0: begin
            s_nxt.addr  = off(s_r.bm, `ADDR_UNLOCK1_W, `ADDR_UNLOCK1_B);
            s_nxt.wdata = `DATA_UNLOCK1;
          end
          3'h1: begin
            s_nxt.addr  = off(s_r.bm, `ADDR_UNLOCK2_W, `ADDR_UNLOCK2_B);
            s_nxt.wdata = `DATA_UNLOCK2;
          end
          3'h2: begin
            s_nxt.addr  = off(s_r.bm, `ADDR_UNLOCK1_W, `ADDR_UNLOCK1_B);
            s_nxt.wdata = (s_r.op == OP_ENTER)   ? `DATA_ENTRY :
                          (s_r.op == OP_PROGRAM) ? `DATA_PROG_SETUP :
                                                   `DATA_EXIT;
            if (s_r.op == OP_ENTER) s_nxt.st = H_DONE;
          end
          default: begin
            // exit tail write lands harmlessly in the idle decoder
            s_nxt.addr  = (s_r.op == OP_EXIT) ? AW'(`ADDR_EXIT_TAIL) : s_r.ua;
            s_nxt.wdata = (s_r.op == OP_EXIT) ? `DATA_EXIT_TAIL : s_r.ud;
            s_nxt.st    = H_DONE;
          end
        endcase
      end
      H_DONE: begin
        s_nxt.st   = H_IDLE;
        s_nxt.done = 1'b1;
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.wr        = s_r.wr;
  assign bus.byte_mode = s_r.bm;
  assign bus.addr      = s_r.addr;
  assign bus.wdata     = s_r.wdata;
  assign o_busy        = s_r.st != H_IDLE;
  assign o_done        = s_r.done;
endmodule

// *** secsi_region_sva.sv ***
`timescale 1ns/1ns
`include "secsi_params.svh"
module secsi_region_sva (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic        wr,
  input  wire logic        byte_mode,
  input  wire logic [23:0] addr,
  input  wire logic [15:0] wdata
);
  // --------
  // host side of the wire
  // --------
  logic [11:0] a1;
  logic [11:0] a2;
  assign a1 = byte_mode ? `ADDR_UNLOCK1_B : `ADDR_UNLOCK1_W;
  assign a2 = byte_mode ? `ADDR_UNLOCK2_B : `ADDR_UNLOCK2_W;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_unl1_addr; wr && wdata == `DATA_UNLOCK1 |-> addr[11:0] == a1; endproperty
  a_unl1_addr: assert property (p_unl1_addr) else $error("first unlock address");
  property p_unl1_run; wr && wdata == `DATA_UNLOCK1 |-> wr [*3]; endproperty
  a_unl1_run: assert property (p_unl1_run) else $error("sequence broken up");
  property p_unl2;
    wr && wdata == `DATA_UNLOCK2 |-> addr[11:0] == a2 && $past(wr)
      && $past(wdata) == `DATA_UNLOCK1;
  endproperty
  a_unl2: assert property (p_unl2) else $error("second unlock out of order");
  property p_entry;
    wr && wdata == `DATA_ENTRY |-> addr[11:0] == a1 && $past(wdata) == `DATA_UNLOCK2;
  endproperty
  a_entry: assert property (p_entry) else $error("entry write malformed");
  property p_setup;
    wr && wdata == `DATA_PROG_SETUP |-> addr[11:0] == a1 && $past(wdata) == `DATA_UNLOCK2;
  endproperty
  a_setup: assert property (p_setup) else $error("program setup malformed");
  property p_prog; wr && wdata == `DATA_PROG_SETUP |=> wr; endproperty
  a_prog: assert property (p_prog) else $error("no data write after setup");
  property p_exit;
    wr && wdata == `DATA_EXIT |-> addr[11:0] == a1 && $past(wdata) == `DATA_UNLOCK2;
  endproperty
  a_exit: assert property (p_exit) else $error("exit write malformed");
  property p_tail;
    wr && wdata == `DATA_EXIT |=> wr && addr[11:0] == `ADDR_EXIT_TAIL
      && wdata == `DATA_EXIT_TAIL;
  endproperty
  a_tail: assert property (p_tail) else $error("exit tail missing");
endmodule

// *** test_secure_region_command_decoder.sv ***
`timescale 1ns/1ns
module test_secure_region_command_decoder;
  import secsi_pkg::*;
  logic        ref_clk;
  logic        arst_n;
  logic        start;
  host_op_t    op;
  logic        bmode;
  logic        busy;
  logic [23:0] taddr;
  logic [15:0] tdata;
  logic [23:0] rd_addr;
  logic        done;
  logic        mapped;
  logic        mapped_2;
  logic        stb;
  logic        preg;
  logic        pfac;
  logic [23:0] paddr;
  logic [15:0] pdata;
  logic        rreg;
  logic [7:0]  rreg_addr;
  logic [41:0] s_prog;
  int          mismatches;
  int          num_checks;
  secsi_if i_secsi_if ();
  secsi_if i_secsi_if_2 ();
  secsi_host i_secsi_host (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .bus(i_secsi_if.host),
    .i_start(start), .i_op(op), .i_byte_mode(bmode), .i_addr(taddr), .i_data(tdata),
    .o_busy(), .o_done(done));
  secsi_dev i_secsi_dev (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .bus(i_secsi_if.dev),
    .i_busy(busy), .o_region_mapped(mapped), .o_prog_stb(stb), .o_prog_region(preg),
    .o_prog_factory(pfac), .o_prog_addr(paddr), .o_prog_data(pdata), .i_rd_addr(rd_addr),
    .o_rd_region(rreg), .o_rd_region_addr(rreg_addr));
  secsi_dev i_secsi_dev_2 (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .bus(i_secsi_if_2.dev),
    .i_busy(1'h0), .o_region_mapped(mapped_2), .o_prog_stb(), .o_prog_region(),
    .o_prog_factory(), .o_prog_addr(), .o_prog_data(), .i_rd_addr(24'h000000),
    .o_rd_region(), .o_rd_region_addr());
  secsi_region_sva i_secsi_region_sva (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
    .wr(i_secsi_if.wr), .byte_mode(i_secsi_if.byte_mode), .addr(i_secsi_if.addr),
    .wdata(i_secsi_if.wdata));
  // --------
  // access tasks
  // --------
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_op(input host_op_t o, input logic b, input logic [23:0] a,
                        input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    start <= 1'h1; op <= o; bmode <= b; taddr <= a; tdata <= d;
    @(posedge ref_clk);
    start <= 1'h0;
    n = 0;
    // look just after each edge so the done pulse is settled when read
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (done !== 1'h1 && n < 20);
    if (done !== 1'h1) mismatches++;
    // program capture lands one edge after the strobe is launched
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [23:0] a, input logic [8:0] exp);
    @(posedge ref_clk);
    rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({rreg, rreg_addr & {8{rreg}}}, exp);
  endtask
  // second bus: a broken sequence, then a valid one; released lines show inverted data
  task automatic bw(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    i_secsi_if_2.wr <= 1'h1; i_secsi_if_2.addr <= {12'h000, a}; i_secsi_if_2.wdata <= d;
  endtask
  task automatic bw_end;
    @(posedge ref_clk);
    i_secsi_if_2.wr <= 1'h0; i_secsi_if_2.wdata <= ~i_secsi_if_2.wdata;
    #1;
  endtask
  always @(posedge ref_clk) if (stb === 1'h1) s_prog <= {preg, pfac, paddr, pdata};
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    close_out;
  end
  // --------
  // tests
  // --------
  initial begin
    arst_n = 1'h0; start = 1'h0; op = OP_ENTER; bmode = 1'h0; busy = 1'h0;
    taddr = 24'h000000; tdata = 16'h0000; rd_addr = 24'h000000;
    mismatches = 0; num_checks = 0;
    i_secsi_if_2.wr = 1'h0; i_secsi_if_2.byte_mode = 1'h0;
    i_secsi_if_2.addr = 24'h000000; i_secsi_if_2.wdata = 16'h0000;
    repeat (16) @(posedge ref_clk);
    chk(mapped, 1'h0);
    arst_n <= 1'h1;
    run_op(OP_ENTER, 1'h0, 24'h000000, 16'h0000);
    chk(mapped, 1'h1);
    rd(24'h0001FF, 9'h1FF);
    rd(24'h100000, 9'h000);
    run_op(OP_PROGRAM, 1'h0, 24'h000085, 16'h1234);
    chk(s_prog, {2'h2, 24'h000085, 16'h1234});
    run_op(OP_PROGRAM, 1'h0, 24'h00007F, 16'h0F0F);
    chk(s_prog, {2'h3, 24'h00007F, 16'h0F0F});
    run_op(OP_PROGRAM, 1'h0, 24'h100000, 16'h4321);
    chk(s_prog[41], 1'h0);
    run_op(OP_EXIT, 1'h0, 24'h000000, 16'h0000);
    chk(mapped, 1'h0);
    rd(24'h0001FF, 9'h000);
    run_op(OP_ENTER, 1'h1, 24'h000000, 16'h0000);
    chk(mapped, 1'h1);
    run_op(OP_EXIT, 1'h1, 24'h000000, 16'h0000);
    chk(mapped, 1'h0);
    busy <= 1'h1;
    run_op(OP_ENTER, 1'h0, 24'h000000, 16'h0000);
    chk(mapped, 1'h0);
    busy <= 1'h0;
    run_op(OP_ENTER, 1'h0, 24'h000000, 16'h0000);
    arst_n <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk(mapped, 1'h0);
    arst_n <= 1'h1;
    bw(12'h555, 16'h00AA); bw(12'h2AA, 16'h0055); bw(12'h555, 16'h0077); bw(12'h555, 16'h0088);
    bw_end;
    chk(mapped_2, 1'h0);
    bw(12'h555, 16'h00AA); bw(12'h2AA, 16'h0055); bw(12'h555, 16'h0088);
    bw_end;
    chk(mapped_2, 1'h1);
    close_out;
  end
endmodule
